// *** verif/test_usd_regs.sv ***
// Purpose: Self-checking bench for the register group.
// Assumes: Accesses wait on PREADY; no fixed latency is relied on.
// Notes: The DMA model supplies byte strobes.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_usd_regs;
   logic CLOCK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [9:0] PADDR = 10'h000;
   logic [31:0] PWDATA = 32'h00000000, PRDATA;
   logic PREADY, PSLVERR, USB_RESET_SEEN = 1'b0, SOF_SEEN = 1'b0, DMA_BYTE_DONE;
   logic [10:0] FRAME_NUMBER = 11'h000;
   logic [3:0] EP_DONE = 4'h0, BUFFER_SELECT = 4'h0, gap = 4'h3;
   logic INTERRUPT_REQUEST_OUT, ROLE_HOST, DATA_POLARITY_SWAP, DMA_START, DMA_REQUEST;
   logic DMA_READ_DIR, ENDPOINT_THREE_DMA, err;
   logic [15:0] DMA_COUNT;
   logic [7:0] rd;
   int err_count = 0;
   int tests_run = 0;
   int bytes_seen = 0;
   always #12.5 CLOCK = ~CLOCK;
   // Counts the byte strobes of the DMA side so the moved length can be judged.
   always @(posedge CLOCK) begin
      if (DMA_BYTE_DONE === 1'b1) begin
         bytes_seen <= bytes_seen + 1;
      end
   end
   usd_regs u_dut (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .USB_RESET_SEEN, .SOF_SEEN, .FRAME_NUMBER, .EP_DONE, .BUFFER_SELECT,
      .DMA_BYTE_DONE, .INTERRUPT_REQUEST_OUT, .ROLE_HOST, .DATA_POLARITY_SWAP, .DMA_START,
      .DMA_REQUEST, .DMA_READ_DIR, .DMA_COUNT, .ENDPOINT_THREE_DMA);
   usd_dma_model u_dma (.clock(CLOCK), .rst(RST), .dma_request(DMA_REQUEST), .gap(gap),
      .dma_byte_done(DMA_BYTE_DONE));
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h000000, d};
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      // Ready is looked at mid-cycle, where it is settled, before the edge that ends the access.
      @(negedge CLOCK);
      while (PREADY !== 1'b1 && n < 50) begin
         @(negedge CLOCK);
         n++;
      end
      if (n >= 50) begin
         err_count++;
      end
      rd = PRDATA[7:0];
      err = PSLVERR;
      @(posedge CLOCK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask : apb
   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(rd, e)
   endtask : rchk
   task automatic t_regs();
      BUFFER_SELECT <= 4'hA;
      rchk(10'h034, 8'h00);
      rchk(10'h038, 8'h0A);
      apb(1'b1, 10'h03C, 8'hFF);
      rchk(10'h03C, 8'hC0);
      `CHK({ROLE_HOST, DATA_POLARITY_SWAP}, 2'b11)
      apb(1'b1, 10'h03C, 8'h40);
      @(negedge CLOCK);
      `CHK({ROLE_HOST, DATA_POLARITY_SWAP}, 2'b01)
      @(posedge CLOCK);
      apb(1'b1, 10'h054, 8'hFF);
      rchk(10'h054, 8'h00);
      apb(1'b0, 10'h3FC, 8'h00);
      `CHK(err, 1'b1)
   endtask : t_regs
   task automatic t_irq();
      EP_DONE <= 4'hF;
      USB_RESET_SEEN <= 1'b1;
      SOF_SEEN <= 1'b1;
      FRAME_NUMBER <= 11'h5A5;
      @(posedge CLOCK);
      EP_DONE <= 4'h0;
      USB_RESET_SEEN <= 1'b0;
      SOF_SEEN <= 1'b0;
      rchk(10'h034, 8'h6F);
      rchk(10'h054, 8'h4A);
      rchk(10'h058, 8'hB0);
      `CHK(INTERRUPT_REQUEST_OUT, 1'b0)
      apb(1'b1, 10'h018, 8'h08);
      rchk(10'h034, 8'h6F);
      `CHK(INTERRUPT_REQUEST_OUT, 1'b1)
      apb(1'b1, 10'h034, 8'h08);
      rchk(10'h034, 8'h67);
      `CHK(INTERRUPT_REQUEST_OUT, 1'b0)
   endtask : t_irq
   task automatic t_dma();
      int n;
      n = 0;
      apb(1'b1, 10'h018, 8'h90);
      apb(1'b1, 10'h0D4, 8'h03);
      apb(1'b1, 10'h0D8, 8'h00);
      `CHK(DMA_REQUEST, 1'b0)
      apb(1'b1, 10'h100, 8'h03);
      apb(1'b1, 10'h0D4, 8'h03);
      apb(1'b1, 10'h0D8, 8'h00);
      rchk(10'h034, 8'hE7);
      `CHK({DMA_REQUEST, INTERRUPT_REQUEST_OUT, DMA_COUNT}, 18'h20003)
      `CHK({DMA_READ_DIR, ENDPOINT_THREE_DMA}, 2'b11)
      @(negedge CLOCK);
      while (DMA_REQUEST === 1'b1 && n < 100) begin
         @(negedge CLOCK);
         n++;
      end
      if (n >= 100) begin
         err_count++;
      end
      @(posedge CLOCK);
      `CHK(bytes_seen, 3)
      rchk(10'h034, 8'h77);
      `CHK(INTERRUPT_REQUEST_OUT, 1'b1)
   endtask : t_dma
   task automatic print_verdict();
      $display("Checks made %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(posedge CLOCK);
      RST <= 1'b0;
      @(posedge CLOCK);
      t_regs();
      t_irq();
      t_dma();
      print_verdict();
   end
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
endmodule : test_usd_regs

// *** verif/usd_dma_model.sv ***
// Purpose: Byte mover on the DMA side, pacing one byte every gap plus one cycles.
// Assumes: Gap of at least one so no byte lands after the last one.
// Notes: Larger gaps model a slow peripheral.
`timescale 1ns/1ps
module usd_dma_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic dma_request,
   input wire logic [3:0] gap,
   output logic dma_byte_done
);
   logic [3:0] wait_count;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_count <= 4'h0;
         dma_byte_done <= 1'b0;
      end else begin
         dma_byte_done <= 1'b0;
         if (!dma_request) begin
            wait_count <= 4'h0;
         end else if (wait_count == gap) begin
            dma_byte_done <= 1'b1;
            wait_count <= 4'h0;
         end else begin
            wait_count <= wait_count + 4'h1;
         end
      end
   end
endmodule : usd_dma_model

// *** verif/usd_regs_properties.sv ***
// Purpose: Port-level checks of the register group.
// Assumes: One clock; outputs lag their control register by one cycle.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module usd_regs_chk (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [usd_pkg::ADDR_W-1:0] PADDR,
   input wire logic PREADY,
   input wire logic INTERRUPT_REQUEST_OUT,
   input wire logic ROLE_HOST,
   input wire logic DATA_POLARITY_SWAP,
   input wire logic DMA_START,
   input wire logic DMA_REQUEST,
   input wire logic DMA_READ_DIR,
   input wire logic [usd_pkg::COUNT_W-1:0] DMA_COUNT,
   input wire logic ENDPOINT_THREE_DMA
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   logic wr;
   logic ctl_wr;
   logic hi_wr;
   logic cnt_wr;
   logic dir_wr;
   assign wr = PSEL && PENABLE && PWRITE;
   assign ctl_wr = wr && PADDR == 10'h03C;
   assign hi_wr = wr && PADDR == 10'h0D8;
   assign cnt_wr = hi_wr || (wr && PADDR == 10'h0D4);
   assign dir_wr = wr && PADDR == 10'h100;
   property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
   a_ready: assert property (p_ready) else $error("access not one cycle");
   property p_role; $changed(ROLE_HOST) |-> $past(ctl_wr, 2); endproperty
   a_role: assert property (p_role) else $error("role moved unasked");
   property p_swap; $changed(DATA_POLARITY_SWAP) |-> $past(ctl_wr, 2); endproperty
   a_swap: assert property (p_swap) else $error("swap moved unasked");
   property p_start; $rose(DMA_START) |-> $past(hi_wr && ENDPOINT_THREE_DMA); endproperty
   a_start: assert property (p_start) else $error("start without cause");
   property p_req; DMA_START |=> DMA_REQUEST && !DMA_START; endproperty
   a_req: assert property (p_req) else $error("bad start pulse");
   property p_count; $changed(DMA_COUNT) |-> $past(cnt_wr, 2); endproperty
   a_count: assert property (p_count) else $error("count moved unasked");
   property p_dir; $changed(DMA_READ_DIR) |-> $past(dir_wr, 2); endproperty
   a_dir: assert property (p_dir) else $error("direction moved unasked");
   property p_ep3; $changed(ENDPOINT_THREE_DMA) |-> $past(dir_wr, 2); endproperty
   a_ep3: assert property (p_ep3) else $error("routing moved unasked");
   property p_irq; $fell(INTERRUPT_REQUEST_OUT) |-> $past(wr, 2); endproperty
   a_irq: assert property (p_irq) else $error("request fell unasked");
   c_dma: cover property ($fell(DMA_REQUEST));
   c_irq: cover property ($rose(INTERRUPT_REQUEST_OUT));
   c_role: cover property ($rose(ROLE_HOST));
endmodule : usd_regs_chk
bind usd_regs usd_regs_chk u_chk (.CLOCK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY,
   .INTERRUPT_REQUEST_OUT, .ROLE_HOST, .DATA_POLARITY_SWAP, .DMA_START, .DMA_REQUEST,
   .DMA_READ_DIR, .DMA_COUNT, .ENDPOINT_THREE_DMA);

// *** verilog/usd_pkg.sv ***
// Purpose: Constants for the USB status, frame number and DMA count register group.
// Assumes: An APB slave with 32-bit data; each register takes one aligned word.
// Notes: Printed offsets are register indices; the byte address is four times the index.
// Overview of operation
// - Status bit 7 reads one while DMA runs, zero after; it never interrupts.
// - Status bits 6, 5, 4 flag bus reset, start-of-frame and DMA completion.
// - Status bits 3 to 0 latch transfer-done for endpoints 3 to 0.
// - Writing status clears each flag written with one; zero leaves it unchanged.
// - Enable bits only gate flags onto the interrupt output, never altering them.
// - Buffer select register shows ping-pong buffer per endpoint; bits 7 to 4 reserved.
// - Control 2 bit 7 selects host role when one, peripheral when zero.
// - Control 2 bit 6 swaps data line polarity when one.
// - Frame low register holds frame bits 6 to 0 in positions 7 to 1.
// - Frame high register holds frame bits 10 to 7 in positions 7 to 4.
// - Both frame registers refresh on every received start-of-frame packet.
// - DMA count is 16 bits split over low and high byte registers.
// - Writing the count high byte starts DMA when DMA enable is set.
// - Endpoint three is routed to the DMA path while DMA enable is set.
// - DMA direction one reads bytes out of the device, zero writes in.

package usd_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int COUNT_W = 16;
   localparam int FRAME_W = 11;
   localparam int EP_N = 4;
   localparam int INDEX_W = 8;

   // Register indices.
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h06;
   localparam logic [7:0] IDX_INTERRUPT_FLAGS = 8'h0D;
   localparam logic [7:0] IDX_BUFFER_SET_SELECT = 8'h0E;
   localparam logic [7:0] IDX_ROLE_POLARITY_CONTROL = 8'h0F;
   localparam logic [7:0] IDX_FRAME_NUMBER_LOW = 8'h15;
   localparam logic [7:0] IDX_FRAME_NUMBER_HIGH = 8'h16;
   localparam logic [7:0] IDX_DMA_COUNT_LOW = 8'h35;
   localparam logic [7:0] IDX_DMA_COUNT_HIGH = 8'h36;
   localparam logic [7:0] IDX_DMA_CONTROL = 8'h40;

   // Interrupt flag fields.
   localparam int FLAG_DMA_BUSY = 7;
   localparam int FLAG_USB_RESET = 6;
   localparam int FLAG_SOF = 5;
   localparam int FLAG_DMA_DONE = 4;
   localparam logic [7:0] FLAG_STICKY_MASK = 8'h7F;

   // Role and polarity fields.
   localparam int CTRL2_HOST = 7;
   localparam int CTRL2_SWAP = 6;

   // DMA control fields.
   localparam int DMACTL_ENABLE = 0;
   localparam int DMACTL_READ_DIR = 1;

   // Frame number placement.
   localparam int FRAME_LOW_BITS = 7;
   localparam int FRAME_LOW_SHIFT = 1;
   localparam int FRAME_HIGH_SHIFT = 4;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [10:0] RST_FRAME = 11'h000;

endpackage : usd_pkg

// *** verilog/usd_regs.sv ***
// Purpose: APB register group for interrupt flags, buffer select, role, frame number, DMA count.
// Assumes: USB engine and DMA path run on CLOCK; their strobes are one-cycle pulses.
// Notes: Every APB access completes without wait states; PREADY rises in the access phase's first cycle.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module usd_regs (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [usd_pkg::ADDR_W-1:0] PADDR,
   input wire logic [usd_pkg::DATA_W-1:0] PWDATA,
   output logic [usd_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic USB_RESET_SEEN,
   input wire logic SOF_SEEN,
   input wire logic [usd_pkg::FRAME_W-1:0] FRAME_NUMBER,
   input wire logic [usd_pkg::EP_N-1:0] EP_DONE,
   input wire logic [usd_pkg::EP_N-1:0] BUFFER_SELECT,
   input wire logic DMA_BYTE_DONE,
   output logic INTERRUPT_REQUEST_OUT,
   output logic ROLE_HOST,
   output logic DATA_POLARITY_SWAP,
   output logic DMA_START,
   output logic DMA_REQUEST,
   output logic DMA_READ_DIR,
   output logic [usd_pkg::COUNT_W-1:0] DMA_COUNT,
   output logic ENDPOINT_THREE_DMA
);

   logic [7:0] flags;
   logic [7:0] irq_enable;
   logic [7:0] ctrl2;
   logic [7:0] dma_ctl;
   logic [7:0] count_low;
   logic [7:0] count_high;
   logic [10:0] frame;
   logic [15:0] remaining;
   logic dma_active;
   logic dma_finish;
   logic setup;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rd_value;
   logic rd_hit;

   function automatic logic sel(input logic [usd_pkg::ADDR_W-1:0] addr,
                                input logic [7:0] idx);
      sel = (addr == {idx, 2'b00});
   endfunction : sel

   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
   assign wbyte = PWDATA[7:0];

   // Completion falls on the last byte, or at once when the count was zero.
   assign dma_finish = dma_active && ((remaining == 16'h0000) ||
                       (DMA_BYTE_DONE && (remaining == 16'h0001)));

   always_comb begin
      rd_value = 8'h00;
      rd_hit = 1'b1;
      if (sel(PADDR, usd_pkg::IDX_INTERRUPT_FLAGS)) begin
         rd_value = {dma_active, flags[6:0]};
      end else if (sel(PADDR, usd_pkg::IDX_IRQ_ENABLE)) begin
         rd_value = irq_enable;
      end else if (sel(PADDR, usd_pkg::IDX_BUFFER_SET_SELECT)) begin
         rd_value = {4'h0, BUFFER_SELECT};
      end else if (sel(PADDR, usd_pkg::IDX_ROLE_POLARITY_CONTROL)) begin
         rd_value = {ctrl2[7:6], 6'h00};
      end else if (sel(PADDR, usd_pkg::IDX_FRAME_NUMBER_LOW)) begin
         rd_value = {frame[6:0], 1'b0};
      end else if (sel(PADDR, usd_pkg::IDX_FRAME_NUMBER_HIGH)) begin
         rd_value = {frame[10:7], 4'h0};
      end else if (sel(PADDR, usd_pkg::IDX_DMA_COUNT_LOW)) begin
         rd_value = count_low;
      end else if (sel(PADDR, usd_pkg::IDX_DMA_COUNT_HIGH)) begin
         rd_value = count_high;
      end else if (sel(PADDR, usd_pkg::IDX_DMA_CONTROL)) begin
         rd_value = {6'h00, dma_ctl[1:0]};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // No wait state: data are sampled in setup so PRDATA can come from a flop.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= setup;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= {24'h000000, rd_value};
         PSLVERR <= !rd_hit;
      end else if (!PSEL) begin
         PSLVERR <= 1'b0;
      end
   end

   // A set arriving in the clearing cycle wins, so no event is lost.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         flags <= usd_pkg::RST_BYTE;
      end else begin
         flags <= (flags & ~((wr_en && sel(PADDR, usd_pkg::IDX_INTERRUPT_FLAGS)) ?
                   (wbyte & usd_pkg::FLAG_STICKY_MASK) : 8'h00))
                  | {1'b0, USB_RESET_SEEN, SOF_SEEN, dma_finish, EP_DONE};
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         irq_enable <= usd_pkg::RST_BYTE;
      end else if (wr_en && sel(PADDR, usd_pkg::IDX_IRQ_ENABLE)) begin
         irq_enable <= wbyte;
      end
   end

   // The enable register only gates; bit 7 is a level and is left out.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         INTERRUPT_REQUEST_OUT <= 1'b0;
      end else begin
         INTERRUPT_REQUEST_OUT <= |(flags & irq_enable & usd_pkg::FLAG_STICKY_MASK);
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl2 <= usd_pkg::RST_BYTE;
      end else if (wr_en && sel(PADDR, usd_pkg::IDX_ROLE_POLARITY_CONTROL)) begin
         ctrl2 <= {wbyte[7:6], 6'h00};
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ROLE_HOST <= 1'b0;
         DATA_POLARITY_SWAP <= 1'b0;
      end else begin
         ROLE_HOST <= ctrl2[usd_pkg::CTRL2_HOST];
         DATA_POLARITY_SWAP <= ctrl2[usd_pkg::CTRL2_SWAP];
      end
   end

   // Writes to the frame registers are dropped; software must not issue them.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         frame <= usd_pkg::RST_FRAME;
      end else if (SOF_SEEN) begin
         frame <= FRAME_NUMBER;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         dma_ctl <= usd_pkg::RST_BYTE;
      end else if (wr_en && sel(PADDR, usd_pkg::IDX_DMA_CONTROL)) begin
         dma_ctl <= {6'h00, wbyte[1:0]};
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         count_low <= usd_pkg::RST_BYTE;
         count_high <= usd_pkg::RST_BYTE;
      end else if (wr_en && sel(PADDR, usd_pkg::IDX_DMA_COUNT_LOW)) begin
         count_low <= wbyte;
      end else if (wr_en && sel(PADDR, usd_pkg::IDX_DMA_COUNT_HIGH)) begin
         count_high <= wbyte;
      end
   end

   // The transfer length is taken from the high write itself, so the low byte
   // must already be in place; a new start while busy restarts the count.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         dma_active <= 1'b0;
         remaining <= usd_pkg::RST_COUNT;
         DMA_START <= 1'b0;
      end else begin
         DMA_START <= 1'b0;
         if (wr_en && sel(PADDR, usd_pkg::IDX_DMA_COUNT_HIGH) &&
             dma_ctl[usd_pkg::DMACTL_ENABLE]) begin
            dma_active <= 1'b1;
            remaining <= {wbyte, count_low};
            DMA_START <= 1'b1;
         end else if (dma_finish) begin
            dma_active <= 1'b0;
            remaining <= usd_pkg::RST_COUNT;
         end else if (dma_active && DMA_BYTE_DONE) begin
            remaining <= remaining - 16'h0001;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         DMA_REQUEST <= 1'b0;
         DMA_READ_DIR <= 1'b0;
         DMA_COUNT <= usd_pkg::RST_COUNT;
         ENDPOINT_THREE_DMA <= 1'b0;
      end else begin
         DMA_REQUEST <= dma_active && !dma_finish;
         DMA_READ_DIR <= dma_ctl[usd_pkg::DMACTL_READ_DIR];
         DMA_COUNT <= {count_high, count_low};
         ENDPOINT_THREE_DMA <= dma_ctl[usd_pkg::DMACTL_ENABLE];
      end
   end

endmodule : usd_regs
